// ### hdl/susc_top.sv
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module susc_top
    import susc_pkg::*;
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [susc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [susc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic                    timer_match,
    input  wire logic                    serial_in_pin,
    input  wire logic                    serial_clock_pin,
    output susc_pkg::susc_pins_t         pins,
    output logic                         irq
);
    import susc_pkg::*;

    // Control register fields.
    logic              start_detect_irq_en;   // Start interrupt enable.
    logic              overflow_irq_en;       // Overflow interrupt enable.
    susc_wire_mode_t   wire_mode_sel;         // Output behaviour.
    susc_clk_src_t     clock_source_sel;      // Shift and counter clock source.
    logic              clock_strobe_bit;      // Counter clock selector under external clock.
    // Status, data and port state.
    logic              start_detect_flag;     // Sticky start flag.
    logic              overflow_flag;         // Sticky overflow flag.
    logic [CNT_W-1:0]  cnt;                   // 4-bit counter.
    logic [7:0]        data;                  // Shift register.
    logic [7:0]        next_data;             // Next shift register value.
    logic              out_latch;             // Output latch after the data MSB.
    logic [7:0]        port;                  // Port and direction bits.
    // Bus slave state.
    logic [ADDR_W-1:0] wr_addr;               // Held write address.
    logic [7:0]        wr_data;               // Held write data, low byte.
    logic              wr_lane;               // Held byte enable of the low lane.
    logic              rd_was_ctrl;           // Last read answered the control register.
    logic              wr_go;                 // Both halves of a write are held.
    logic              wr_hit;                // Write address is mapped.
    logic              ctrl_wr;               // Write strobes, one per register.
    logic              stat_wr;
    logic              data_wr;
    logic              port_wr;
    // Pin sampling and clocking.
    logic              sda_s;                 // Synchronised data input.
    logic              scl_s;                 // Synchronised clock input.
    logic              sda_d;                 // Delayed copies for edge finding.
    logic              scl_d;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_det;             // Start condition on the bus.
    logic              sw_strobe;             // Software clock strobe.
    logic              tc_strobe;             // Toggle clock strobe.
    logic              shift_clk;             // Shift register clock pulse.
    logic              cnt_clk;               // Counter clock pulse.
    logic              latch_open;            // Output latch is transparent.
    logic              scl_hold;              // Clock line hold request.
    susc_pins_t        next_pins;             // Next pin drive.

    // Both serial inputs cross into the clock domain here.
    susc_sync #(.WIDTH(2)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     ({serial_in_pin, serial_clock_pin}),
        .dout    ({sda_s, scl_s})
    );

    // Edge finding on the synchronised inputs.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sda_d <= 1'b0;
            scl_d <= 1'b0;
        end else begin
            sda_d <= sda_s;
            scl_d <= scl_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;
    // A start is SDA falling while SCL is high; only armed in two-wire modes.
    assign start_det = wire_mode_sel[1] & scl_s & scl_d & ~sda_s & sda_d;

    // Write decode; a write needs the low byte lane to touch any register.
    assign wr_go   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    assign wr_hit  = (wr_addr == CTRL_OFS) | (wr_addr == STAT_OFS) |
                     (wr_addr == DATA_OFS) | (wr_addr == PORT_OFS);
    assign ctrl_wr = wr_go & wr_lane & (wr_addr == CTRL_OFS);
    assign stat_wr = wr_go & wr_lane & (wr_addr == STAT_OFS);
    assign data_wr = wr_go & wr_lane & (wr_addr == DATA_OFS);
    assign port_wr = wr_go & wr_lane & (wr_addr == PORT_OFS);

    // Write channels: address and data are taken in either order, then answered.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            wr_addr       <= '0;
            wr_data       <= REG_RESET;
            wr_lane       <= 1'b0;
        end else begin
            // Address taken and held until the write completes.
            if (s_axi_awready && s_axi_awvalid) begin
                s_axi_awready <= 1'b0;
                wr_addr       <= s_axi_awaddr;
            end
            // Data taken and held until the write completes.
            if (s_axi_wready && s_axi_wvalid) begin
                s_axi_wready <= 1'b0;
                wr_data      <= s_axi_wdata[7:0];
                wr_lane      <= s_axi_wstrb[0];
            end
            // Unmapped addresses answer with a slave error.
            if (wr_go) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: one read at a time, data registered with the answer.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
            rd_was_ctrl   <= 1'b0;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            rd_was_ctrl   <= (s_axi_araddr == CTRL_OFS);
            case (s_axi_araddr)
                // Both strobe bits always read as zero.
                CTRL_OFS: s_axi_rdata <= {24'h000000, start_detect_irq_en, overflow_irq_en,
                                          wire_mode_sel, clock_source_sel, 2'h0};
                STAT_OFS: s_axi_rdata <= {24'h000000, start_detect_flag, overflow_flag,
                                          2'h0, cnt};
                DATA_OFS: s_axi_rdata <= {24'h000000, data};
                PORT_OFS: s_axi_rdata <= {24'h000000, port};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Control register; every field clears at reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_detect_irq_en <= 1'b0;
            overflow_irq_en     <= 1'b0;
            wire_mode_sel       <= WM_OFF;
            clock_source_sel    <= CS_STROBE;
            clock_strobe_bit    <= 1'b0;
        end else if (ctrl_wr) begin
            start_detect_irq_en <= wr_data[CTRL_SIE];
            overflow_irq_en     <= wr_data[CTRL_OIE];
            wire_mode_sel       <= susc_wire_mode_t'(wr_data[CTRL_WM_HI:CTRL_WM_LO]);
            clock_source_sel    <= susc_clk_src_t'(wr_data[CTRL_CS_HI:CTRL_CS_LO]);
            // Kept only as a selector; it is never shown on a read.
            clock_strobe_bit    <= wr_data[CTRL_CLK];
        end
    end

    // Software strobes come from the control write itself.
    assign sw_strobe = ctrl_wr & wr_data[CTRL_CLK] &
                       (wr_data[CTRL_CS_HI:CTRL_CS_LO] == CS_STROBE);
    assign tc_strobe = ctrl_wr & wr_data[CTRL_TC];

    // Shift register clock from the selected source; inputs ignore the wire mode.
    always_comb begin
        case (clock_source_sel)
            CS_STROBE:  shift_clk = sw_strobe;
            CS_TIMER:   shift_clk = timer_match;
            CS_EXT_POS: shift_clk = scl_rise;
            CS_EXT_NEG: shift_clk = scl_fall;
            default:    shift_clk = 1'b0;
        endcase
        // A strobe written with source 00 clocks at once, whatever source was stored.
        if (sw_strobe) begin
            shift_clk = 1'b1;
        end
    end

    // Counter clock; under an external source the strobe bit picks toggle strobes.
    always_comb begin
        case (clock_source_sel)
            CS_STROBE: cnt_clk = sw_strobe;
            CS_TIMER:  cnt_clk = timer_match;
            default:   cnt_clk = clock_strobe_bit ? tc_strobe : (scl_rise | scl_fall);
        endcase
        // The same strobe also steps the counter in its own write cycle.
        if (sw_strobe) begin
            cnt_clk = 1'b1;
        end
    end

    // A write to the data register wins over a shift in the same cycle.
    always_comb begin
        next_data = data;
        if (data_wr) begin
            next_data = wr_data;
        end else if (shift_clk) begin
            // The synchronised input was sampled in an earlier cycle.
            next_data = {data[6:0], sda_s};
        end
    end

    // Shift register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data <= REG_RESET;
        end else begin
            data <= next_data;
        end
    end

    // Latch open in the half cycle before the sampling edge, else always open.
    always_comb begin
        case (clock_source_sel)
            CS_EXT_POS: latch_open = ~scl_s;
            CS_EXT_NEG: latch_open = scl_s;
            default:    latch_open = 1'b1;
        endcase
    end

    // Output latch takes the new MSB while open.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_latch <= 1'b0;
        end else if (latch_open) begin
            out_latch <= next_data[7];
        end
    end

    // Counter; a CPU write wins over an increment.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= '0;
        end else if (stat_wr) begin
            cnt <= wr_data[STAT_CNT_HI:0];
        end else if (cnt_clk) begin
            cnt <= cnt + CNT_ONE;
        end
    end

    // Sticky flags: a status write blocks a counter set in its cycle; only a two-wire start sets over a clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_detect_flag <= 1'b0;
            overflow_flag     <= 1'b0;
        end else begin
            start_detect_flag <= (wire_mode_sel[1] ? start_det : (cnt_clk & ~stat_wr)) |
                                 (start_detect_flag & ~(stat_wr & wr_data[STAT_SIF]));
            overflow_flag     <= (cnt_clk & ~stat_wr & (cnt == CNT_MAX)) |
                                 (overflow_flag & ~(stat_wr & wr_data[STAT_OIF]));
        end
    end

    // Interrupt follows any flag whose enable is set.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= (start_detect_flag & start_detect_irq_en) |
                   (overflow_flag & overflow_irq_en);
        end
    end

    // Port bits; the toggle strobe inverts the clock port bit whatever its direction.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port <= REG_RESET;
        end else if (port_wr) begin
            port <= wr_data;
        end else if (tc_strobe) begin
            port[PORT_CK] <= ~port[PORT_CK];
        end
    end

    // Clock hold from a start in two-wire, or from overflow in mode three.
    assign scl_hold = (wire_mode_sel[1] & start_detect_flag) |
                      ((wire_mode_sel == WM_TWO_HOLD) & overflow_flag);

    // Pin drive as a function of the wire mode.
    always_comb begin
        // Plain port behaviour: port bit drives, pull-up when an input with port one.
        next_pins.do_out     = port[PORT_DO];
        next_pins.do_oe      = port[DDR_DO];
        next_pins.do_pullup  = port[PORT_DO] & ~port[DDR_DO];
        next_pins.sda_out    = port[PORT_DI];
        next_pins.sda_oe     = port[DDR_DI];
        next_pins.sda_pullup = port[PORT_DI] & ~port[DDR_DI];
        next_pins.scl_out    = port[PORT_CK];
        next_pins.scl_oe     = port[DDR_CK];
        next_pins.scl_pullup = port[PORT_CK] & ~port[DDR_CK];
        case (wire_mode_sel)
            WM_OFF: begin
                next_pins.do_out = port[PORT_DO];
            end
            WM_THREE: begin
                // Direction and pull-up stay with the port bits.
                next_pins.do_out = out_latch;
            end
            WM_TWO, WM_TWO_HOLD: begin
                // Open drain: only ever drives low.
                next_pins.sda_out    = 1'b0;
                next_pins.sda_oe     = port[DDR_DI] & ~(out_latch & port[PORT_DI]);
                next_pins.scl_out    = 1'b0;
                next_pins.scl_oe     = port[DDR_CK] & (~port[PORT_CK] | scl_hold);
                next_pins.sda_pullup = 1'b0;
                next_pins.scl_pullup = 1'b0;
            end
            default: begin
                next_pins.do_out = port[PORT_DO];
            end
        endcase
    end

    // Pins come from flip-flops.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins <= '0;
        end else begin
            pins <= next_pins;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_irq_start: assert property (start_detect_flag && start_detect_irq_en |=> irq)
        else $error("start flag with enable did not raise irq");
    chk_irq_ovf: assert property (overflow_flag && overflow_irq_en |=> irq)
        else $error("overflow flag with enable did not raise irq");
    chk_off_ports: assert property (wire_mode_sel == WM_OFF |=>
                                    pins.do_out == $past(port[PORT_DO]))
        else $error("mode zero data pin not following port bit");
    chk_three_data: assert property (wire_mode_sel == WM_THREE |=>
                                     pins.do_out == $past(out_latch))
        else $error("three-wire data pin not following latch");
    chk_sda_drain: assert property (wire_mode_sel[1] |=> !pins.sda_out &&
                     pins.sda_oe == $past(port[DDR_DI] && !(out_latch && port[PORT_DI])))
        else $error("two-wire SDA drive wrong");
    chk_start_hold: assert property (wire_mode_sel[1] && port[DDR_CK] && start_detect_flag
                                     |=> pins.scl_oe && !pins.scl_out)
        else $error("SCL not held after start");
    chk_pullups_off: assert property (wire_mode_sel[1] |=>
                                      !pins.sda_pullup && !pins.scl_pullup)
        else $error("pull-ups active in two-wire mode");
    chk_ovf_hold: assert property (wire_mode_sel == WM_TWO_HOLD && port[DDR_CK] &&
                                   overflow_flag |=> pins.scl_oe)
        else $error("SCL not held after overflow");
    chk_strobe_count: assert property (sw_strobe && !stat_wr |=>
                                       cnt == 4'($past(cnt) + CNT_ONE))
        else $error("software strobe did not step counter");
    chk_strobe_zero: assert property (s_axi_rvalid && rd_was_ctrl |->
                                      s_axi_rdata[1:0] == 2'h0)
        else $error("strobe bits read nonzero");
    chk_toggle_pin: assert property (tc_strobe |=> port[PORT_CK] != $past(port[PORT_CK]))
        else $error("toggle strobe did not invert clock bit");

    cov_start_hold: cover property (start_detect_flag && pins.scl_oe);
    cov_overflow:   cover property (overflow_flag && irq);
    cov_ext_shift:  cover property (clock_source_sel == CS_EXT_POS && shift_clk);
    cov_tc_count:   cover property (clock_strobe_bit && tc_strobe && cnt_clk);

endmodule // susc_top

// ### hdl/susc_pkg.sv
package susc_pkg;

    // Register bus address width and register byte offsets.
    localparam int          ADDR_W   = 8;
    localparam logic [7:0]  CTRL_OFS = 8'h00;   // Interrupt enables, wire mode, clock source.
    localparam logic [7:0]  STAT_OFS = 8'h04;   // Sticky flags and counter value.
    localparam logic [7:0]  DATA_OFS = 8'h08;   // Shift register.
    localparam logic [7:0]  PORT_OFS = 8'h0c;   // Port output and direction bits of the pins.

    // Control register field positions.
    localparam int CTRL_SIE   = 7;
    localparam int CTRL_OIE   = 6;
    localparam int CTRL_WM_HI = 5;
    localparam int CTRL_WM_LO = 4;
    localparam int CTRL_CS_HI = 3;
    localparam int CTRL_CS_LO = 2;
    localparam int CTRL_CLK   = 1;
    localparam int CTRL_TC    = 0;

    // Status register field positions.
    localparam int STAT_SIF   = 7;
    localparam int STAT_OIF   = 6;
    localparam int STAT_CNT_HI = 3;

    // Port register field positions.
    localparam int PORT_DO = 0;
    localparam int PORT_DI = 1;
    localparam int PORT_CK = 2;
    localparam int DDR_DO  = 4;
    localparam int DDR_DI  = 5;
    localparam int DDR_CK  = 6;

    // Reset values and counter limits.
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int         CNT_W     = 4;
    localparam logic [3:0] CNT_MAX   = 4'hf;
    localparam logic [3:0] CNT_ONE   = 4'h1;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Output behaviour of the serial pins.
    typedef enum logic [1:0] {WM_OFF, WM_THREE, WM_TWO, WM_TWO_HOLD} susc_wire_mode_t;

    // Clock source of the shift register and counter.
    typedef enum logic [1:0] {CS_STROBE, CS_TIMER, CS_EXT_POS, CS_EXT_NEG} susc_clk_src_t;

    // Everything the block drives onto the three serial pins.
    typedef struct packed {
        logic do_out;
        logic do_oe;
        logic do_pullup;
        logic sda_out;
        logic sda_oe;
        logic sda_pullup;
        logic scl_out;
        logic scl_oe;
        logic scl_pullup;
    } susc_pins_t;

endpackage

// ### hdl/susc_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for pins that come from outside the clock domain.
module susc_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;   // First stage, read only by the second stage.

    // Both stages clear to zero under reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // susc_sync

// ### bench/susc_peer.sv
`timescale 1ns/1ps
// Far-side serial peer that drives the data and clock wires seen by the block.
module susc_peer
    import susc_pkg::*;
(
    input  wire susc_pkg::susc_pins_t pins,
    input  wire logic                 din,
    output logic                      serial_in_pin,
    output logic                      serial_clock_pin
);
    logic ck = 1'b1;  // Peer clock, which stands high between frames.
    // Both wires idle high by pull-up, and the block can only pull them low.
    assign serial_clock_pin = ck & ~(pins.scl_oe & ~pins.scl_out);
    assign serial_in_pin    = din & ~(pins.sda_oe & ~pins.sda_out);
    // Emits a number of clock edges at the 800 ns link period.
    task automatic pulse(input int n);
        repeat (n) begin
            #400 ck <= ~ck;
        end
    endtask
endmodule // susc_peer

// ### bench/test_susc_top.sv
`timescale 1ns/1ps
// Self-checking bench that drives the register bus and the serial peer.
module test_susc_top;
    import susc_pkg::*;
    logic aclk = 0, aresetn = 0, timer_match = 0, din = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, r, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic irq, serial_in_pin, serial_clock_pin;
    logic [1:0] s_axi_bresp, s_axi_rresp, b;
    susc_pins_t pins;
    int n_errors = 0, check_count = 0, seed = 43;
    susc_top u_susc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_match,
        .serial_in_pin, .serial_clock_pin, .pins, .irq);
    susc_peer u_susc_peer (.pins, .din, .serial_in_pin, .serial_clock_pin);
    // The clock runs at 10 MHz.
    initial forever #50 aclk = ~aclk;
    // Compares one value and counts the result.
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task test_done;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One register write; each channel is released at its own handshake.
    task reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge aclk); while (!s_axi_bvalid);
        b = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    // One register read; the data are taken at the edge that shows rvalid.
    task reg_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        r = s_axi_rdata;
        s_axi_rready <= 0;
    endtask
    // Reads a register and compares it.
    task rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        reg_rd(a);
        chk(nm, r, exp);
    endtask
    // Lets pin and interrupt updates and the input synchroniser settle.
    task settle;
        repeat (6) @(posedge aclk);
    endtask
    // Main sequence of scenarios.
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        rc("ctrl", CTRL_OFS, 0);
        chk("pins", pins, 0);
        rc("stat", STAT_OFS, 0);
        rc("unmapped", 8'h10, 0);
        chk("rresp", s_axi_rresp, RESP_SLVERR);
        reg_wr(8'h10, 8'hff);
        chk("bresp", b, RESP_SLVERR);
        d = $random(seed) & 32'hff;
        reg_wr(DATA_OFS, d[7:0]);
        chk("bresp", b, RESP_OKAY);
        reg_wr(CTRL_OFS, 8'h10);
        reg_wr(PORT_OFS, 8'h10);
        settle;
        chk("do_oe", pins.do_oe, 1);
        chk("do_out", pins.do_out, d[7]);
        reg_wr(CTRL_OFS, 8'h12);
        d = ((d << 1) | 1) & 32'hff;
        rc("data", DATA_OFS, d);
        rc("stat", STAT_OFS, 8'h81);
        rc("ctrl", CTRL_OFS, 8'h10);
        chk("do_out", pins.do_out, d[7]);
        reg_wr(STAT_OFS, 8'hcf);
        reg_wr(CTRL_OFS, 8'h12);
        rc("stat", STAT_OFS, 8'hc0);
        chk("irq", irq, 0);
        reg_wr(CTRL_OFS, 8'h50);
        settle;
        chk("irq", irq, 1);
        reg_wr(STAT_OFS, 8'h40);
        settle;
        chk("irq", irq, 0);
        reg_wr(CTRL_OFS, 8'h90);
        settle;
        chk("irq", irq, 1);
        reg_wr(STAT_OFS, 8'h80);
        reg_wr(CTRL_OFS, 8'h04);
        chk("irq", irq, 0);
        timer_match <= 1;
        @(posedge aclk);
        timer_match <= 0;
        rc("stat", STAT_OFS, 8'h81);
        reg_wr(STAT_OFS, 8'h80);
        reg_wr(CTRL_OFS, 8'h08);
        u_susc_peer.pulse(2);
        settle;
        rc("stat", STAT_OFS, 8'h82);
        reg_wr(CTRL_OFS, 8'h0a);
        reg_wr(CTRL_OFS, 8'h0b);
        rc("stat", STAT_OFS, 8'h83);
        rc("port", PORT_OFS, 8'h14);
        reg_wr(STAT_OFS, 8'hc0);
        reg_wr(CTRL_OFS, 8'h20);
        reg_wr(PORT_OFS, 8'h40);
        settle;
        chk("scl_oe", pins.scl_oe, 1);
        chk("pullups", {pins.sda_pullup, pins.scl_pullup}, 0);
        reg_wr(PORT_OFS, 8'h44);
        settle;
        chk("scl_oe", pins.scl_oe, 0);
        din <= 0;
        settle;
        chk("scl_oe", pins.scl_oe, 1);
        reg_wr(STAT_OFS, 8'h80);
        settle;
        chk("scl_oe", pins.scl_oe, 0);
        reg_wr(PORT_OFS, 8'h64);
        settle;
        chk("sda_oe", pins.sda_oe, 1);
        reg_wr(STAT_OFS, 8'h0f);
        reg_wr(CTRL_OFS, 8'h32);
        settle;
        chk("scl_oe", pins.scl_oe, 1);
        rc("stat", STAT_OFS, 8'h40);
        reg_wr(STAT_OFS, 8'h40);
        settle;
        chk("scl_oe", pins.scl_oe, 0);
        reg_wr(PORT_OFS, 8'h00);
        reg_wr(CTRL_OFS, 8'h0c);
        reg_wr(DATA_OFS, 8'h00);
        din <= 1;
        settle;
        u_susc_peer.pulse(2);
        settle;
        rc("data", DATA_OFS, 8'h01);
        test_done;
    end
    // Watchdog that cuts a hang short.
    initial begin
        #2000000;
        n_errors++;
        test_done;
    end
endmodule // test_susc_top
